/* File: verilog/spd_pkg.sv */
package spd_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] TAP_ZERO = 8'h00;
    localparam logic [7:0] TAP_CENTER = 8'h80;
    localparam logic [7:0] TAP_TOP = 8'hff;
    localparam logic PUMP_RESET = 1'b1;
    localparam int BIT_C7 = 7;
    localparam int BIT_C6 = 6;
    localparam int BIT_C5 = 5;
    localparam int BIT_C4 = 4;
    localparam int BIT_C3 = 3;
    localparam int BIT_C2 = 2;
    localparam logic [7:0] WIPER_WRITE_CMD = 8'h00;
    localparam logic [7:0] SHUTDOWN_CLEAR_CMD = 8'h80;
    localparam logic [7:0] OPEN_HIGH_KEEP_TAP_CMD = 8'h90;
    localparam logic [7:0] OPEN_HIGH_TAP_ZERO_CMD = 8'h91;
    localparam logic [7:0] OPEN_HIGH_TAP_CENTER_CMD = 8'h92;
    localparam logic [7:0] OPEN_HIGH_TAP_TOP_CMD = 8'h93;
    localparam logic [7:0] OPEN_LOW_KEEP_TAP_CMD = 8'h88;
    localparam logic [7:0] OPEN_LOW_TAP_ZERO_CMD = 8'h89;
    localparam logic [7:0] OPEN_LOW_TAP_CENTER_CMD = 8'h8a;
    localparam logic [7:0] OPEN_LOW_TAP_TOP_CMD = 8'h8b;
    localparam logic [7:0] OPEN_SLIDER_MASK = 8'hfc;
    localparam logic [7:0] OPEN_SLIDER_CMD = 8'h84;
    localparam logic [7:0] PUMP_DISABLE_CMD = 8'ha0;
    localparam logic [7:0] PUMP_ENABLE_CMD = 8'ha1;
    localparam logic [7:0] DEVICE_RESET_CMD = 8'hc0;
    typedef enum logic [1:0] {
        SPD_TAP_KEEP = 2'b00,
        SPD_TAP_ZERO = 2'b01,
        SPD_TAP_CENTER = 2'b10,
        SPD_TAP_TOP = 2'b11
    } spd_tap_t;
    typedef enum logic [1:0] {
        SPD_SD_NONE = 2'b00,
        SPD_SD_HIGH = 2'b01,
        SPD_SD_LOW = 2'b10,
        SPD_SD_SLIDER = 2'b11
    } spd_sd_t;
endpackage : spd_pkg

/* File: verilog/spd_shift.sv */
`timescale 1ns/1ns
module spd_shift
    import spd_pkg::*;
(
    // Reset.
    input wire logic rst,
    // Serial link.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // Completed frame.
    output logic [15:0] frame_data,
    output logic frame_tgl
);
    import spd_pkg::*;

    typedef struct packed {
        logic [15:0] sh;
        logic [CNT_W-1:0] cnt;
        logic [15:0] data;
        logic tgl;
    } spd_shift_t;

    spd_shift_t s_r;
    spd_shift_t s_nxt;

    // Chip select high clears the count asynchronously, so a short frame leaves no trace.
    always_comb begin
        s_nxt = s_r;
        s_nxt.sh = {s_r.sh[14:0], din};
        if (s_r.cnt == CNT_W'(FRAME_BITS - 1)) begin
            s_nxt.data = {s_r.sh[14:0], din};
            s_nxt.tgl = ~s_r.tgl;
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + 5'h01;
        end
    end

    // Reset clears the toggle as well, so both sides of the crossing start from one level.
    // Falling edge shift.
    always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (cs_n) begin
            s_r.cnt <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign frame_data = s_r.data;
    assign frame_tgl = s_r.tgl;
endmodule : spd_shift

/* File: verilog/spd_sync.sv */
`timescale 1ns/1ns
module spd_sync
    import spd_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Event toggle from the link domain.
    input wire logic tgl_in,
    output logic pulse
);
    import spd_pkg::*;

    typedef struct packed {
        logic [2:0] sy;
        logic p;
    } spd_sync_t;

    spd_sync_t s_r;
    spd_sync_t s_nxt;

    // The first stage feeds only the second; the edge test looks at stages two and three.
    always_comb begin
        s_nxt.sy = {s_r.sy[1:0], tgl_in};
        s_nxt.p = s_r.sy[1] ^ s_r.sy[2];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pulse = s_r.p;
endmodule : spd_sync

/* File: verilog/spd_decoder.sv */
`timescale 1ns/1ns
module spd_decoder
    import spd_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Serial link pins.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // Potentiometer control.
    output logic [7:0] wiper_position,
    output logic [7:0] tap_select,
    output logic high_open,
    output logic low_open,
    output logic slider_open,
    output logic pump_on,
    output logic frame_done
);
    import spd_pkg::*;

    logic [15:0] frame_data;
    logic frame_tgl;
    logic frame_pulse;

    spd_shift u_shift (
        .rst(rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .frame_data(frame_data),
        .frame_tgl(frame_tgl)
    );

    spd_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .tgl_in(frame_tgl),
        .pulse(frame_pulse)
    );

    typedef struct packed {
        logic [7:0] wiper;
        logic [7:0] tap;
        spd_sd_t sd;
        spd_tap_t force_tap;
        logic pump;
        logic done;
        logic hi;
        logic lo;
        logic sl;
    } spd_state_t;

    spd_state_t s_r;
    spd_state_t s_nxt;

    function automatic logic [7:0] tap_of(input spd_tap_t f, input logic [7:0] w);
        logic [7:0] t;
        t = w;
        unique case (f)
            SPD_TAP_KEEP: t = w;
            SPD_TAP_ZERO: t = TAP_ZERO;
            SPD_TAP_CENTER: t = TAP_CENTER;
            SPD_TAP_TOP: t = TAP_TOP;
        endcase
        return t;
    endfunction : tap_of

    // Shutdown decodes are shared by the command logic and by its checks.
    function automatic logic is_open_high(input logic [7:0] c);
        return c[7:2] == OPEN_HIGH_KEEP_TAP_CMD[7:2];
    endfunction : is_open_high

    function automatic logic is_open_low(input logic [7:0] c);
        return c[7:2] == OPEN_LOW_KEEP_TAP_CMD[7:2];
    endfunction : is_open_low

    function automatic logic is_open_slider(input logic [7:0] c);
        return (c & OPEN_SLIDER_MASK) == OPEN_SLIDER_CMD;
    endfunction : is_open_slider

    function automatic logic is_known(input logic [7:0] c);
        return (c == WIPER_WRITE_CMD) || (c == SHUTDOWN_CLEAR_CMD) || is_open_high(c) ||
            is_open_low(c) || is_open_slider(c) || (c == PUMP_ENABLE_CMD) ||
            (c == PUMP_DISABLE_CMD) || (c == DEVICE_RESET_CMD);
    endfunction : is_known

    logic [7:0] cmd;
    logic [7:0] dat;
    assign cmd = frame_data[15:8];
    assign dat = frame_data[7:0];

    // Frame data is stable for many link cycles after the toggle, so reading it on the
    // synchronised pulse is safe as long as frames are not spaced closer than four mclk.
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (frame_pulse) begin
            s_nxt.done = 1'b1;
            if (cmd == WIPER_WRITE_CMD) begin
                if (s_r.sd == SPD_SD_NONE) begin
                    s_nxt.wiper = dat;
                end
            end else if (cmd == SHUTDOWN_CLEAR_CMD) begin
                s_nxt.sd = SPD_SD_NONE;
                s_nxt.force_tap = SPD_TAP_KEEP;
            end else if (is_open_high(cmd)) begin
                s_nxt.sd = SPD_SD_HIGH;
                s_nxt.force_tap = spd_tap_t'(cmd[1:0]);
            end else if (is_open_low(cmd)) begin
                s_nxt.sd = SPD_SD_LOW;
                s_nxt.force_tap = spd_tap_t'(cmd[1:0]);
            end else if (is_open_slider(cmd)) begin
                s_nxt.sd = SPD_SD_SLIDER;
                s_nxt.force_tap = SPD_TAP_KEEP;
            end else if (cmd == PUMP_ENABLE_CMD) begin
                s_nxt.pump = 1'b1;
            end else if (cmd == PUMP_DISABLE_CMD) begin
                s_nxt.pump = 1'b0;
            end else if (cmd == DEVICE_RESET_CMD) begin
                s_nxt.wiper = WIPER_RESET;
                s_nxt.pump = PUMP_RESET;
                s_nxt.sd = SPD_SD_NONE;
                s_nxt.force_tap = SPD_TAP_KEEP;
            end
        end
        s_nxt.tap = tap_of(s_nxt.force_tap, s_nxt.wiper);
        // Open flags get flops of their own so the pins never see decode glitches.
        s_nxt.hi = (s_nxt.sd == SPD_SD_HIGH);
        s_nxt.lo = (s_nxt.sd == SPD_SD_LOW);
        s_nxt.sl = (s_nxt.sd == SPD_SD_SLIDER);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r.wiper <= WIPER_RESET;
            s_r.tap <= WIPER_RESET;
            s_r.sd <= SPD_SD_NONE;
            s_r.force_tap <= SPD_TAP_KEEP;
            s_r.pump <= PUMP_RESET;
            s_r.done <= 1'b0;
            s_r.hi <= 1'b0;
            s_r.lo <= 1'b0;
            s_r.sl <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wiper_position = s_r.wiper;
    assign tap_select = s_r.tap;
    assign high_open = s_r.hi;
    assign low_open = s_r.lo;
    assign slider_open = s_r.sl;
    assign pump_on = s_r.pump;
    assign frame_done = s_r.done;

    a_write_blocked: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == WIPER_WRITE_CMD && s_r.sd != SPD_SD_NONE)
            |=> $stable(wiper_position))
        else $error("wiper changed during shutdown");

    a_write_lands: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == WIPER_WRITE_CMD && s_r.sd == SPD_SD_NONE)
            |=> (wiper_position == $past(dat)) && (tap_select == $past(dat)))
        else $error("wiper write not applied");

    a_clear_restore: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == SHUTDOWN_CLEAR_CMD)
            |=> !high_open && !low_open && !slider_open && tap_select == wiper_position)
        else $error("clear did not restore");

    a_pump_held: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd[7] && !cmd[6] && !cmd[5]) |=> $stable(pump_on))
        else $error("shutdown changed pump");

    a_high_force: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_HIGH_TAP_TOP_CMD)
            |=> high_open && tap_select == TAP_TOP && $stable(wiper_position))
        else $error("high full shutdown wrong");

    a_low_force: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_LOW_TAP_ZERO_CMD)
            |=> low_open && !high_open && tap_select == TAP_ZERO)
        else $error("low zero shutdown wrong");

    a_pump_off: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == PUMP_DISABLE_CMD) |=> !pump_on)
        else $error("pump not disabled");

    a_soft_reset: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == DEVICE_RESET_CMD)
            |=> wiper_position == WIPER_RESET && pump_on && !high_open && !low_open)
        else $error("reset command incomplete");

    a_slider_tap: assert property (@(posedge mclk) disable iff (rst)
        slider_open |-> tap_select == wiper_position)
        else $error("slider tap not stored value");

    a_high_keep: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_HIGH_KEEP_TAP_CMD)
            |=> high_open && !low_open && tap_select == wiper_position)
        else $error("high keep shutdown wrong");

    a_high_center: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_HIGH_TAP_CENTER_CMD)
            |=> high_open && tap_select == TAP_CENTER && $stable(wiper_position))
        else $error("high mid shutdown wrong");

    a_low_keep: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_LOW_KEEP_TAP_CMD)
            |=> low_open && !high_open && tap_select == wiper_position)
        else $error("low keep shutdown wrong");

    a_low_top: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == OPEN_LOW_TAP_TOP_CMD)
            |=> low_open && tap_select == TAP_TOP && $stable(wiper_position))
        else $error("low full shutdown wrong");

    a_slider_open: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && is_open_slider(cmd))
            |=> slider_open && !high_open && !low_open)
        else $error("slider shutdown wrong");

    a_pump_on: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && cmd == PUMP_ENABLE_CMD) |=> pump_on)
        else $error("pump not enabled");

    a_unknown_kept: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && !is_known(cmd))
            |=> $stable(wiper_position) && $stable(tap_select) && $stable(pump_on) &&
                $stable(high_open) && $stable(low_open) && $stable(slider_open))
        else $error("unknown command changed state");

    a_mode_replace: assert property (@(posedge mclk) disable iff (rst)
        (frame_pulse && is_open_low(cmd) && (high_open || slider_open))
            |=> low_open && !high_open && !slider_open)
        else $error("shutdown modes combined");

    a_tap_follows: assert property (@(posedge mclk) disable iff (rst)
        (!high_open && !low_open) |-> tap_select == wiper_position)
        else $error("tap differs from stored wiper");

    a_frame_only: assert property (@(posedge mclk) disable iff (rst)
        !frame_pulse
            |=> $stable(wiper_position) && $stable(tap_select) && $stable(pump_on) &&
                $stable(high_open) && $stable(low_open) && $stable(slider_open))
        else $error("state changed without a frame");

    a_done_source: assert property (@(posedge mclk) disable iff (rst)
        frame_done |-> $past(frame_pulse))
        else $error("done without a complete frame");

    a_done_single: assert property (@(posedge mclk) disable iff (rst)
        frame_done |=> !frame_done)
        else $error("done held too long");

    a_reset_value: assert property (@(posedge mclk)
        rst |=> wiper_position == WIPER_RESET && tap_select == WIPER_RESET && pump_on &&
            !high_open && !low_open && !slider_open && !frame_done)
        else $error("reset state wrong");
endmodule : spd_decoder

/* File: sim/spd_host.sv */
`timescale 1ns/1ns
module spd_host (
    // Serial link.
    output logic sclk,
    output logic cs_n,
    output logic din
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // First nbits bits of the frame, most significant bit first.
    task automatic send(input logic [15:0] word, input int nbits);
        int i;
        cs_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            din = word[15 - i];
            #7;
            sclk = 1'b0;
            #8;
            sclk = 1'b1;
        end
        #7;
        cs_n = 1'b1;
        // A released line must not keep its last bit, or a stale match could pass.
        din = ~din;
    endtask : send
endmodule : spd_host

/* File: sim/spd_decoder_bench.sv */
`timescale 1ns/1ns
module spd_decoder_bench;
    import spd_pkg::*;
    logic mclk = 1'b0;
    logic rst;
    logic sclk, cs_n, din, high_open, low_open, slider_open, pump_on, frame_done;
    logic [7:0] wiper_position, tap_select, ew, et;
    logic eh, el, es, ep;
    logic [7:0] sd_cmds [10] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h88, 8'h89, 8'h8a, 8'h8b,
        8'h84, 8'h87};
    logic [7:0] bad_cmds [5] = '{8'h01, 8'h81, 8'ha2, 8'hc1, 8'hff};
    int err_total = 0;
    int checks_done = 0;
    int i;
    always #50 mclk = ~mclk;
    spd_decoder u_spd_decoder (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .wiper_position(wiper_position), .tap_select(tap_select), .high_open(high_open),
        .low_open(low_open), .slider_open(slider_open), .pump_on(pump_on),
        .frame_done(frame_done));
    spd_host u_spd_host (.sclk(sclk), .cs_n(cs_n), .din(din));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk_all();
        chk("wiper_position", ew, wiper_position);
        chk("tap_select", et, tap_select);
        chk("opens_pump", {4'h0, eh, el, es, ep},
            {4'h0, high_open, low_open, slider_open, pump_on});
    endtask : chk_all
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data);
        int n;
        casez (cmd)
            8'h00: begin
                if (!(eh | el | es)) begin
                    ew = data;
                    et = data;
                end
            end
            8'h80: begin
                {eh, el, es} = 3'b000;
                et = ew;
            end
            8'b1001_00??, 8'b1000_10??: begin
                eh = cmd[4];
                el = cmd[3];
                es = 1'b0;
                et = (cmd[1:0] == 2'b00) ? ew : (cmd[1:0] == 2'b01) ? 8'h00 :
                    (cmd[1:0] == 2'b10) ? 8'h80 : 8'hff;
            end
            8'b1000_01??: begin
                {eh, el, es} = 3'b001;
                et = ew;
            end
            8'ha0: ep = 1'b0;
            8'ha1: ep = 1'b1;
            8'hc0: begin
                ew = 8'h80;
                et = 8'h80;
                {eh, el, es, ep} = 4'b0001;
            end
            default: ;
        endcase
        u_spd_host.send({cmd, data}, 16);
        n = 0;
        while (frame_done !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if (frame_done !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED frame_done expected 1 seen %b", frame_done);
            results();
        end
        chk_all();
        @(negedge mclk);
        chk("frame_done", 8'h00, {7'h0, frame_done});
    endtask : frame
    initial begin
        rst <= 1'b1;
        ew = 8'h80;
        et = 8'h80;
        {eh, el, es, ep} = 4'b0001;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk_all();
        frame(8'h00, 8'h00);
        frame(8'h00, 8'hff);
        frame(8'h00, 8'h37);
        for (i = 0; i < 10; i++) begin
            frame(sd_cmds[i], 8'h5a);
            frame(8'h00, 8'h11);
        end
        frame(8'h80, 8'hff);
        frame(8'ha0, 8'h01);
        frame(8'h93, 8'h00);
        frame(8'h80, 8'h00);
        frame(8'ha1, 8'h00);
        for (i = 0; i < 5; i++) begin
            frame(bad_cmds[i], 8'h00);
        end
        u_spd_host.send(16'h0042, 10);
        repeat (12) begin
            @(negedge mclk);
            chk("frame_done", 8'h00, {7'h0, frame_done});
        end
        chk_all();
        frame(8'h00, 8'h66);
        frame(8'ha0, 8'h00);
        frame(8'h8a, 8'h00);
        frame(8'hc0, 8'h00);
        frame(8'h00, 8'h24);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        ew = 8'h80;
        et = 8'h80;
        {eh, el, es, ep} = 4'b0001;
        @(negedge mclk);
        chk_all();
        frame(8'h00, 8'h5c);
        results();
    end
endmodule : spd_decoder_bench
